/* File: lebp_port.sv */
// primary master port for the local execution bus
`timescale 1ns/1ps
`default_nettype none
module lebp_port #(
  parameter logic [3:0] SETUP_CYCLES = lebp_pkg::SETUP_CYC_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // user side
  input  wire logic                        reqValid,
  input  wire logic                        reqRead,
  input  wire logic                        reqWord,
  input  wire logic                        reqLock,
  input  wire logic [lebp_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [lebp_pkg::DATA_W-1:0] reqWdata,
  input  wire logic                        optimized,
  input  wire logic [3:0]                  optSetup,
  output var  logic                        reqReady,
  output var  logic                        rspValid,
  output var  logic [lebp_pkg::DATA_W-1:0] rspRdata,
  // bus side
  input  wire logic [lebp_pkg::DATA_W-1:0] dataLinesIn,
  output var  logic [lebp_pkg::DATA_W-1:0] dataLinesOut,
  output var  logic                        dataLinesOe,
  output var  logic [lebp_pkg::ADDR_W-1:0] addressLines,
  output var  logic [lebp_pkg::CTRL_W-1:0] controlLines,
  output var  logic                        upperByteSelect,
  output var  logic                        addrCtrlOe,
  output var  logic                        addressValidStrobeN,
  output var  logic                        dataValidStrobeN,
  output var  logic                        strobeOe,
  input  wire logic                        slaveAckN,
  input  wire logic                        secondMasterRequestN,
  output var  logic                        secondMasterGrantN
);
  typedef struct packed {
    lebp_pkg::lebp_state_t         state;
    logic                          isRead;
    logic [lebp_pkg::DATA_W-1:0]   dOut;
    logic                          dOe;
    logic [lebp_pkg::ADDR_W-1:0]   addr;
    logic [lebp_pkg::CTRL_W-1:0]   ctrl;
    logic                          ubs;
    logic                          acOe;
    logic                          asN;
    logic                          dsN;
    logic                          sOe;
    logic                          ready;
    logic                          rValid;
    logic [lebp_pkg::DATA_W-1:0]   rData;
  } lebp_port_st_t;

  lebp_port_st_t st_reg;
  lebp_port_st_t st_next;

  logic       paceLoad;
  logic       paceDone;
  logic [3:0] paceCount;
  logic       granted;
  logic       busy;

  // optimized mode lets the caller shorten strobe spacing
  assign paceCount = optimized ? optSetup : SETUP_CYCLES;
  assign busy      = (st_reg.state != lebp_pkg::ST_IDLE) && (st_reg.state != lebp_pkg::ST_GRANT);
  assign granted   = ~secondMasterGrantN;

  lebp_pace lebp_pace_i (
    .clk   (clk),
    .nrst  (nrst),
    .load  (paceLoad),
    .count (paceCount),
    .done  (paceDone)
  );

  // a new user request blocks a grant for one cycle, but a grant registered the edge before the request still wins over it in idle
  lebp_arb lebp_arb_i (
    .clk    (clk),
    .nrst   (nrst),
    .reqN   (secondMasterRequestN),
    .busy   (busy),
    .hold   (reqValid && st_reg.ready),
    .grantN (secondMasterGrantN)
  );

  // transfer sequencer; the pace count ends the address phase, acknowledge ends the data phase
  always_comb begin
    st_next        = st_reg;
    st_next.rValid = 1'b0;
    paceLoad       = 1'b0;
    case (st_reg.state)
      lebp_pkg::ST_IDLE: begin
        st_next.ready = 1'b1;
        if (granted) begin
          // float everything while the secondary owns the bus
          st_next.state = lebp_pkg::ST_GRANT;
          st_next.acOe  = 1'b0;
          st_next.dOe   = 1'b0;
          st_next.sOe   = 1'b0;
          st_next.ready = 1'b0;
        end else if (reqValid && st_reg.ready) begin
          st_next.state  = lebp_pkg::ST_ADDR;
          st_next.isRead = reqRead;
          st_next.addr   = reqAddr;
          st_next.ubs    = reqWord | reqAddr[0];
          st_next.ctrl   = '0;
          st_next.ctrl[lebp_pkg::CTRL_RNW] = reqRead;
          st_next.ctrl[lebp_pkg::CTRL_UBS] = reqWord;
          st_next.ctrl[lebp_pkg::CTRL_LCK] = reqLock;
          st_next.acOe   = 1'b1;
          st_next.sOe    = 1'b1;
          st_next.dOut   = reqWdata;
          st_next.dOe    = ~reqRead;
          st_next.asN    = 1'b0;
          st_next.ready  = 1'b0;
          paceLoad       = 1'b1;
        end
      end
      lebp_pkg::ST_ADDR: begin
        // data strobe follows the address strobe after the setup spacing
        if (paceDone) begin
          st_next.state = lebp_pkg::ST_DATA;
          st_next.dsN   = 1'b0;
        end
      end
      lebp_pkg::ST_DATA: begin
        if (!slaveAckN) begin
          st_next.state = lebp_pkg::ST_CLOSE;
          st_next.asN   = 1'b1;
          st_next.dsN   = 1'b1;
          if (st_reg.isRead) begin
            st_next.rData = dataLinesIn;
          end
          st_next.rValid = 1'b1;
        end
      end
      lebp_pkg::ST_CLOSE: begin
        // wait for acknowledge release so sequences never overlap
        st_next.dOe = 1'b0;
        if (slaveAckN) begin
          st_next.state = lebp_pkg::ST_IDLE;
        end
      end
      lebp_pkg::ST_GRANT: begin
        // only one secondary exists, so its release returns the bus here
        if (!granted) begin
          st_next.state = lebp_pkg::ST_IDLE;
          st_next.acOe  = 1'b1;
          st_next.sOe   = 1'b1;
          st_next.asN   = 1'b1;
          st_next.dsN   = 1'b1;
        end
      end
      default: begin
        st_next.state = lebp_pkg::ST_IDLE;
      end
    endcase
  end

  // primary drives strobes idle-high from reset as default owner
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.state <= lebp_pkg::ST_IDLE;
      st_reg.asN   <= 1'b1;
      st_reg.dsN   <= 1'b1;
      st_reg.acOe  <= 1'b1;
      st_reg.sOe   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reqReady            = st_reg.ready;
  assign rspValid            = st_reg.rValid;
  assign rspRdata            = st_reg.rData;
  assign dataLinesOut        = st_reg.dOut;
  assign dataLinesOe         = st_reg.dOe;
  assign addressLines        = st_reg.addr;
  assign controlLines        = st_reg.ctrl;
  assign upperByteSelect     = st_reg.ubs;
  assign addrCtrlOe          = st_reg.acOe;
  assign addressValidStrobeN = st_reg.asN;
  assign dataValidStrobeN    = st_reg.dsN;
  assign strobeOe            = st_reg.sOe;
endmodule : lebp_port
`default_nettype wire

/* File: lebp_pkg.sv */
// shared constants and types for the local execution bus port
package lebp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int CTRL_W = 3;

  // control line bit positions
  localparam int CTRL_RNW = 0;
  localparam int CTRL_UBS = 1;
  localparam int CTRL_LCK = 2;

  // non-optimized sequence spacing, in ns
  localparam int SETUP_NS = 16;
  localparam int CLK_NS   = 8;
  localparam int SETUP_CYC_I = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETUP_CYC = (SETUP_CYC_I < 1) ? 4'h1 : SETUP_CYC_I[3:0];
  localparam logic [3:0] SETUP_CYC_DEF = SETUP_CYC;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_CLOSE,
    ST_GRANT
  } lebp_state_t;
endpackage : lebp_pkg

/* File: lebp_pace.sv */
// programmable pacing counter for strobe placement
`timescale 1ns/1ps
`default_nettype none
module lebp_pace (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [3:0] count,
  output var  logic       done
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       done;
  } lebp_pace_st_t;

  lebp_pace_st_t st_reg;
  lebp_pace_st_t st_next;

  // counts down after load; done is a one-cycle pulse at zero
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load) begin
      st_next.cnt = count;
    end else if (st_reg.cnt != 4'h0) begin
      st_next.cnt = st_reg.cnt - 4'h1;
      if (st_reg.cnt == 4'h1) begin
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;
endmodule : lebp_pace
`default_nettype wire

/* File: lebp_arb.sv */
// primary-side ownership tracker for the secondary master exchange
`timescale 1ns/1ps
`default_nettype none
module lebp_arb (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic reqN,
  input  wire logic busy,
  input  wire logic hold,
  output var  logic grantN
);
  typedef struct packed {
    logic granted;
  } lebp_arb_st_t;

  lebp_arb_st_t st_reg;
  lebp_arb_st_t st_next;

  // grant only between transfers; release once request drops
  always_comb begin
    st_next = st_reg;
    if (!st_reg.granted && !reqN && !busy && !hold) begin
      st_next.granted = 1'b1;
    end else if (st_reg.granted && reqN) begin
      st_next.granted = 1'b0;
    end
  end

  // primary owns the bus out of reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign grantN = ~st_reg.granted;
endmodule : lebp_arb
`default_nettype wire

/* File: lebp_port_properties.sv */
// timing assertions on the primary master port
`timescale 1ns/1ps
`default_nettype none
module lebp_port_properties (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        reqValid,
  input wire logic                        reqReady,
  input wire logic                        rspValid,
  input wire logic [lebp_pkg::CTRL_W-1:0] controlLines,
  input wire logic                        dataLinesOe,
  input wire logic                        addrCtrlOe,
  input wire logic                        strobeOe,
  input wire logic                        addressValidStrobeN,
  input wire logic                        dataValidStrobeN,
  input wire logic                        slaveAckN,
  input wire logic                        secondMasterRequestN,
  input wire logic                        secondMasterGrantN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_idle_grant; reqReady && !reqValid && !secondMasterRequestN |=> !secondMasterGrantN; endproperty
  a_idle_grant: assert property (p_idle_grant) else $error("idle request not granted");
  property p_float; $past(!secondMasterGrantN) && !secondMasterGrantN |-> !addrCtrlOe && !strobeOe && !dataLinesOe; endproperty
  a_float: assert property (p_float) else $error("drivers on while granted");
  property p_hold; !secondMasterGrantN && !secondMasterRequestN |=> !secondMasterGrantN; endproperty
  a_hold: assert property (p_hold) else $error("grant dropped early");
  property p_back; secondMasterRequestN && !secondMasterGrantN |=> secondMasterGrantN; endproperty
  a_back: assert property (p_back) else $error("grant not withdrawn");
  property p_ack_done; rspValid |-> $past(!slaveAckN); endproperty
  a_ack_done: assert property (p_ack_done) else $error("done without acknowledge");
  property p_close; !dataValidStrobeN && !slaveAckN |=> addressValidStrobeN && dataValidStrobeN && rspValid; endproperty
  a_close: assert property (p_close) else $error("transfer not closed");
  property p_order; !dataValidStrobeN |-> !addressValidStrobeN; endproperty
  a_order: assert property (p_order) else $error("data strobe outside address phase");
  property p_dir; !addressValidStrobeN |-> dataLinesOe == !controlLines[lebp_pkg::CTRL_RNW]; endproperty
  a_dir: assert property (p_dir) else $error("data direction wrong");
  property p_start; $fell(addressValidStrobeN) |-> addrCtrlOe && $past(reqValid && reqReady); endproperty
  a_start: assert property (p_start) else $error("address phase without request");
endmodule : lebp_port_properties
`default_nettype wire

/* File: lebp_slave_model.sv */
// behavioural slave memory with adjustable acknowledge delay
`timescale 1ns/1ps
`default_nettype none
module lebp_slave_model (
  input  wire logic        clk,
  input  wire logic [3:0]  lat,
  input  wire logic [23:0] addressLines,
  input  wire logic [2:0]  controlLines,
  input  wire logic [15:0] dataLinesOut,
  input  wire logic        dataLinesOe,
  input  wire logic        addressValidStrobeN,
  input  wire logic        dataValidStrobeN,
  output var  logic        slaveAckN,
  output var  logic [15:0] dataLinesIn
);
  logic [15:0] mem [16];
  logic [3:0]  cnt = 4'h0;
  initial slaveAckN = 1'b1;
  // ack stays low until the data strobe returns high, so no fixed count ends a transfer
  always @(posedge clk) begin
    if (dataValidStrobeN) begin
      cnt <= 4'h0;
      slaveAckN <= 1'b1;
    end else if (cnt < lat) begin
      cnt <= cnt + 4'h1;
    end else begin
      slaveAckN <= 1'b0;
      if (!controlLines[lebp_pkg::CTRL_RNW]) mem[addressLines[3:0]] <= dataLinesOut;
    end
  end
  // released lines float high through the pull-ups
  assign dataLinesIn = dataLinesOe ? dataLinesOut : (!addressValidStrobeN &&
    controlLines[lebp_pkg::CTRL_RNW]) ? mem[addressLines[3:0]] : 16'hffff;
endmodule : lebp_slave_model
`default_nettype wire

/* File: lebp_port_tb.sv */
// self-checking bench for the primary master port
`timescale 1ns/1ps
`default_nettype none
module lebp_port_tb;
  logic        clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqRead = 1'b0, reqWord = 1'b1;
  logic        reqLock = 1'b0, optimized = 1'b0, secondMasterRequestN = 1'b1;
  logic [23:0] reqAddr = 24'h0, addressLines;
  logic [15:0] reqWdata = 16'h0, rspRdata, dataLinesIn, dataLinesOut;
  logic [3:0]  optSetup = 4'h1, lat = 4'h0;
  logic [2:0]  controlLines;
  logic        reqReady, rspValid, dataLinesOe, addrCtrlOe, upperByteSelect, strobeOe;
  logic        addressValidStrobeN, dataValidStrobeN, slaveAckN, secondMasterGrantN;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  lebp_port lebp_port_i (.clk, .nrst, .reqValid, .reqRead, .reqWord, .reqLock, .reqAddr,
    .reqWdata, .optimized, .optSetup, .reqReady, .rspValid, .rspRdata, .dataLinesIn,
    .dataLinesOut, .dataLinesOe, .addressLines, .controlLines, .upperByteSelect, .addrCtrlOe,
    .addressValidStrobeN, .dataValidStrobeN, .strobeOe, .slaveAckN, .secondMasterRequestN,
    .secondMasterGrantN);
  lebp_slave_model lebp_slave_model_i (.clk, .lat, .addressLines, .controlLines, .dataLinesOut,
    .dataLinesOe, .addressValidStrobeN, .dataValidStrobeN, .slaveAckN, .dataLinesIn);
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // one transfer; n counts edges from take to the done pulse
  task automatic xfer(input logic rd, input logic [23:0] a, input logic [15:0] d, input int mn);
    int         n;
    logic [2:0] c;
    n = 0;
    do @(posedge clk); while (reqReady !== 1'b1);
    // expected control word, built after the caller's settings have landed
    c = 3'h0;
    c[lebp_pkg::CTRL_RNW] = rd;
    c[lebp_pkg::CTRL_UBS] = reqWord;
    c[lebp_pkg::CTRL_LCK] = reqLock;
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= a;
    reqWdata <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      // first edge after the take shows the address phase
      if (n == 1) begin
        chk(addressLines === a && controlLines === c, "addr/ctrl");
        chk(addressValidStrobeN === 1'b0 && addrCtrlOe === 1'b1, "addr strobe");
        chk(upperByteSelect === (reqWord | a[0]), "byte select");
        chk(dataLinesOe === !rd, "data direction");
      end
    end while (rspValid !== 1'b1 && n < 40);
    chk(n >= mn && n < 40, "completion timing");
    if (rd) chk(rspRdata === d, "read data");
  endtask : xfer
  task automatic t_rw(input logic [3:0] l, input logic [23:0] a, input int s);
    lat <= l;
    xfer(1'b0, a, {a[7:0], 8'h5a}, s + 4 + l);
    xfer(1'b1, a, {a[7:0], 8'h5a}, s + 4 + l);
  endtask : t_rw
  // secondary asks while idle, then again during a slow locked transfer
  task automatic t_grant();
    // start from an idle port so the grant latency is known
    do @(posedge clk); while (reqReady !== 1'b1);
    secondMasterRequestN <= 1'b0;
    repeat (3) @(posedge clk);
    chk(secondMasterGrantN === 1'b0, "grant");
    chk(addrCtrlOe === 1'b0 && strobeOe === 1'b0 && dataLinesOe === 1'b0, "float");
    secondMasterRequestN <= 1'b1;
    repeat (3) @(posedge clk);
    chk(secondMasterGrantN === 1'b1 && addrCtrlOe === 1'b1, "ownership back");
    lat <= 4'h8;
    reqLock <= 1'b1;
    fork
      xfer(1'b0, 24'h000003, 16'h0f0f, 14);
      begin
        repeat (3) @(posedge clk);
        secondMasterRequestN <= 1'b0;
        repeat (6) @(posedge clk);
        chk(secondMasterGrantN === 1'b1, "grant during transfer");
      end
    join
    reqLock <= 1'b0;
    repeat (3) @(posedge clk);
    chk(secondMasterGrantN === 1'b0, "grant after transfer");
    secondMasterRequestN <= 1'b1;
  endtask : t_grant
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(secondMasterGrantN === 1'b1 && reqReady === 1'b1 && addrCtrlOe === 1'b1, "reset");
    t_rw(4'h0, 24'hfffff1, 2);
    // byte transfers at an even address leave the upper byte unselected
    reqWord <= 1'b0;
    t_rw(4'h5, 24'h800002, 2);
    reqWord <= 1'b1;
    optimized <= 1'b1;
    t_rw(4'h0, 24'h000004, 1);
    optimized <= 1'b0;
    t_grant();
    report_and_stop();
  end
endmodule : lebp_port_tb
bind lebp_port lebp_port_properties lebp_port_properties_i (.clk, .nrst, .reqValid, .reqReady,
  .rspValid, .controlLines, .dataLinesOe, .addrCtrlOe, .strobeOe, .addressValidStrobeN,
  .dataValidStrobeN, .slaveAckN, .secondMasterRequestN, .secondMasterGrantN);
`default_nettype wire
